// >>> hba_pkg.sv
// Constants shared by the ISA host bus port and its input synchroniser.
// Assumes a single 40 MHz core clock; ISA pins are asynchronous to it.
`default_nettype none
package hba_pkg;
   // Core clock period and the shortest system reset pulse that counts
   localparam int CLK_PERIOD_NS = 25;
   localparam int RESET_MIN_NS = 40;
   localparam int RESET_MIN_CYC_I = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] RESET_MIN_CYC = RESET_MIN_CYC_I[2:0];
   // Bus widths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int N_IRQ = 10;
   localparam int N_DMA = 4;
   // Address compare masks: full decode in auto mode, low eleven lines in manual mode
   localparam logic [15:0] AUTO_MASK = 16'hffff;
   localparam logic [15:0] MAN_MASK = 16'h07ff;
   // Serial channels span eight registers, the printer port four
   localparam logic [15:0] UART_SPAN_MASK = 16'hfff8;
   localparam logic [15:0] PP_SPAN_MASK = 16'hfffc;
   localparam logic [2:0] UART_REG_MASK = 3'h7;
   localparam logic [2:0] PP_REG_MASK = 3'h3;
   // Interrupt line select code meaning "not routed"
   localparam logic [3:0] IRQ_NONE = 4'hf;
   // Idle (reset) levels of the synchronised pin vector, high bit first:
   // man_b, iow_b, ior_b, aen, tc, dack_b[3:0], sys_reset, addr[15:0], data[7:0]
   localparam int SYNC_W = 34;
   // Strobes, acknowledges and MAN high; AEN, TC, reset, address and data low
   localparam logic [33:0] SYNC_IDLE = 34'h3_9e00_0000;
endpackage
`default_nettype wire

// >>> hba_sync.sv
// Three-stage synchroniser for a vector of asynchronous ISA pins.
// Assumes the pins are quasi-static around each change; the output level
// only moves once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module hba_sync #(
   parameter int W = 8,
   parameter logic [W-1:0] IDLE = '0
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [W-1:0] i_pin,
   output logic [W-1:0] o_lvl
);
   logic [W-1:0] s1; // Meta stage, read only by s2
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // Each bit filters independently so a skewed bus settles bit by bit
   genvar b;
   generate
      for (b = 0; b < W; b = b + 1) begin : g_bit
         always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               s1[b] <= IDLE[b];
               s2[b] <= IDLE[b];
               s3[b] <= IDLE[b];
               o_lvl[b] <= IDLE[b];
            end else begin
               s1[b] <= i_pin[b];
               s2[b] <= s1[b];
               s3[b] <= s2[b];
               // Accept a change only once two late stages agree
               if (s2[b] == s3[b]) begin
                  o_lvl[b] <= s3[b];
               end
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// >>> hba_port.sv
// ISA host bus port: address decode, register strobes, data bus drive,
// interrupt and DMA request routing, channel ready and system reset.
// Assumes base addresses and IRQ/DMA routing come from configuration logic
// on the same clock; serial channels return read data the cycle after O_RD_STB.
`timescale 1ns/1ps
`default_nettype none
module hba_port
   import hba_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W,
   parameter int NI = N_IRQ,
   parameter int ND = N_DMA
) (
   input wire logic I_MCLK,
   input wire logic I_RST_B,
   input wire logic I_RESET,
   input wire logic I_MAN_B,
   input wire logic [AW-1:0] I_ADDR,
   input wire logic I_AEN,
   input wire logic I_IOR_B,
   input wire logic I_IOW_B,
   input wire logic [DW-1:0] I_DATA,
   output logic [DW-1:0] O_DATA,
   output logic O_DATA_OE,
   input wire logic I_CFG_DONE,
   input wire logic [AW-1:0] I_BASE_A,
   input wire logic [AW-1:0] I_BASE_B,
   input wire logic [AW-1:0] I_BASE_P,
   output logic O_SEL_A,
   output logic O_SEL_B,
   output logic O_SEL_P,
   output logic O_DMA_CYC,
   output logic [2:0] O_REG_ADDR,
   output logic O_RD_STB,
   output logic O_WR_STB,
   output logic [DW-1:0] O_WR_DATA,
   input wire logic [DW-1:0] I_RD_DATA_A,
   input wire logic [DW-1:0] I_RD_DATA_B,
   input wire logic [DW-1:0] I_RD_DATA_P,
   input wire logic I_INT_A,
   input wire logic I_INT_B,
   input wire logic I_INT_P,
   input wire logic [3:0] I_IRQ_SEL_A,
   input wire logic [3:0] I_IRQ_SEL_B,
   input wire logic [3:0] I_IRQ_SEL_P,
   output logic [NI-1:0] O_IRQ,
   output logic [NI-1:0] O_IRQ_OE,
   input wire logic I_DMA_EN,
   input wire logic [1:0] I_DMA_SEL,
   input wire logic I_PP_DREQ,
   output logic [ND-1:0] O_DREQ,
   output logic [ND-1:0] O_DREQ_OE,
   input wire logic [ND-1:0] I_DACK_B,
   input wire logic I_TC,
   output logic O_DMA_ACK,
   output logic O_TC_DONE,
   input wire logic I_PP_WAIT,
   output logic O_IOCHRDY,
   output logic O_IOCHRDY_OE,
   output logic O_SYS_CLR
);
   logic [SYNC_W-1:0] lvl; // Filtered pin levels
   logic [SYNC_W-1:0] lvl_d; // Previous filtered levels for edges
   logic [2:0] rst_cnt; // Length of the current system reset pulse
   logic rd_act; // A decoded read is in progress
   logic rd_oe_pend; // Read data to be captured this cycle, one cycle after O_RD_STB
   logic sys_clr; // System reset has been long enough

   // Filter every asynchronous pin through three stages
   hba_sync #(.W(SYNC_W), .IDLE(SYNC_IDLE)) u_sync (
      .i_clk(I_MCLK),
      .i_rst_b(I_RST_B),
      .i_pin({I_MAN_B, I_IOW_B, I_IOR_B, I_AEN, I_TC, I_DACK_B, I_RESET, I_ADDR, I_DATA}),
      .o_lvl(lvl)
   );

   // Field views of the filtered vector
   wire [DW-1:0] data_lvl = lvl[7:0];
   wire [AW-1:0] addr_lvl = lvl[23:8];
   wire rst_lvl = lvl[24];
   wire [ND-1:0] dack_b_lvl = lvl[28:25];
   wire tc_lvl = lvl[29];
   wire aen_lvl = lvl[30];
   wire ior_lvl = lvl[31];
   wire iow_lvl = lvl[32];
   wire man_mode = ~lvl[33];

   // Strobe edges on the filtered levels
   wire ior_fall = lvl_d[31] & ~ior_lvl;
   wire ior_rise = ~lvl_d[31] & ior_lvl;
   wire iow_rise = ~lvl_d[32] & iow_lvl;
   wire tc_rise = ~lvl_d[29] & tc_lvl;

   // Address decode; manual mode ignores A11-A15 so standard PC bases alias
   wire [AW-1:0] dec_mask = man_mode ? MAN_MASK : AUTO_MASK;
   wire cfg_ok = man_mode | I_CFG_DONE;
   wire io_ok = cfg_ok & ~aen_lvl;
   wire dec_a = (((addr_lvl ^ I_BASE_A) & dec_mask & UART_SPAN_MASK) == '0);
   wire dec_b = (((addr_lvl ^ I_BASE_B) & dec_mask & UART_SPAN_MASK) == '0);
   wire dec_p = (((addr_lvl ^ I_BASE_P) & dec_mask & PP_SPAN_MASK) == '0);

   // DMA acknowledge of the selected channel; the host drives it
   wire dack_sel = I_DMA_EN & ~dack_b_lvl[I_DMA_SEL];
   wire dma_cyc = aen_lvl & dack_sel;
   // Channel A wins an overlapping base so only one target ever answers
   wire hit_a = io_ok & dec_a;
   wire hit_b = io_ok & dec_b & ~dec_a;
   wire hit_p = (io_ok & dec_p & ~dec_a & ~dec_b) | dma_cyc;
   wire hit = hit_a | hit_b | hit_p;
   // Printer uses two register bits, a DMA cycle always hits its data port
   wire [2:0] reg_sel = dma_cyc ? 3'h0 : addr_lvl[2:0] & (hit_p ? PP_REG_MASK : UART_REG_MASK);
   // Read data mux; bit 0 stays bit 0 end to end
   wire [DW-1:0] rd_mux = O_SEL_A ? I_RD_DATA_A : (O_SEL_B ? I_RD_DATA_B : I_RD_DATA_P);
   // Wait states only while the parallel port owns an open cycle
   wire wait_now = I_PP_WAIT & O_SEL_P & (~ior_lvl | ~iow_lvl) & ~sys_clr;

   // Edge history
   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         lvl_d <= SYNC_IDLE;
      end else begin
         lvl_d <= lvl;
      end
   end

   // System reset pin: a pulse shorter than the minimum is treated as a glitch
   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         rst_cnt <= 3'h0;
         sys_clr <= 1'b0;
      end else begin
         rst_cnt <= (rst_lvl && rst_cnt != RESET_MIN_CYC) ? rst_cnt + 3'h1 : (rst_lvl ? rst_cnt : 3'h0);
         sys_clr <= rst_lvl & (rst_cnt + 3'h1 >= RESET_MIN_CYC);
      end
   end

   // Register access strobes, target select and register address
   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         {O_SEL_A, O_SEL_B, O_SEL_P, O_DMA_CYC} <= 4'h0;
         O_REG_ADDR <= 3'h0;
         O_RD_STB <= 1'b0;
         O_WR_STB <= 1'b0;
         O_WR_DATA <= '0;
      end else if (sys_clr) begin
         {O_SEL_A, O_SEL_B, O_SEL_P, O_DMA_CYC} <= 4'h0;
         O_RD_STB <= 1'b0;
         O_WR_STB <= 1'b0;
      end else begin
         O_RD_STB <= ior_fall & hit;
         O_WR_STB <= iow_rise & hit;
         if ((ior_fall | iow_rise) & hit) begin
            {O_SEL_A, O_SEL_B, O_SEL_P, O_DMA_CYC} <= {hit_a, hit_b, hit_p, dma_cyc};
            O_REG_ADDR <= reg_sel;
         end
         if (iow_rise & hit) begin
            O_WR_DATA <= data_lvl;
         end
      end
   end

   // Data bus drive: only from two cycles after O_RD_STB until the read strobe rises
   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         rd_act <= 1'b0;
         rd_oe_pend <= 1'b0;
         O_DATA <= '0;
         O_DATA_OE <= 1'b0;
      end else if (sys_clr || ior_rise) begin
         rd_act <= 1'b0;
         rd_oe_pend <= 1'b0;
         O_DATA_OE <= 1'b0;
      end else begin
         // Targets answer the cycle after their strobe, so capture one cycle later
         rd_oe_pend <= O_RD_STB;
         if (ior_fall & hit) begin
            rd_act <= 1'b1;
         end
         if (rd_oe_pend) begin
            O_DATA <= rd_mux;
            O_DATA_OE <= rd_act;
         end
      end
   end

   // Interrupt lines: a line drives only when some source is routed to it
   genvar i;
   generate
      for (i = 0; i < NI; i = i + 1) begin : g_irq
         wire use_a = (I_IRQ_SEL_A == 4'(i));
         wire use_b = (I_IRQ_SEL_B == 4'(i));
         wire use_p = (I_IRQ_SEL_P == 4'(i));
         always_ff @(posedge I_MCLK or negedge I_RST_B) begin
            if (!I_RST_B) begin
               O_IRQ[i] <= 1'b0;
               O_IRQ_OE[i] <= 1'b0;
            end else begin
               O_IRQ[i] <= ~sys_clr & ((use_a & I_INT_A) | (use_b & I_INT_B) | (use_p & I_INT_P));
               O_IRQ_OE[i] <= ~sys_clr & (use_a | use_b | use_p);
            end
         end
      end
      // DMA request lines; unselected lines float onto their pull-downs
      for (i = 0; i < ND; i = i + 1) begin : g_dreq
         wire own = I_DMA_EN & (I_DMA_SEL == 2'(i));
         always_ff @(posedge I_MCLK or negedge I_RST_B) begin
            if (!I_RST_B) begin
               O_DREQ[i] <= 1'b0;
               O_DREQ_OE[i] <= 1'b0;
            end else begin
               O_DREQ[i] <= ~sys_clr & own & I_PP_DREQ;
               O_DREQ_OE[i] <= ~sys_clr & own;
            end
         end
      end
   endgenerate

   // Acknowledge, terminal count and channel ready
   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_DMA_ACK <= 1'b0;
         O_TC_DONE <= 1'b0;
         O_IOCHRDY <= 1'b1;
         O_IOCHRDY_OE <= 1'b0;
         O_SYS_CLR <= 1'b0;
      end else begin
         O_DMA_ACK <= ~sys_clr & dack_sel;
         O_TC_DONE <= ~sys_clr & tc_rise & dack_sel;
         O_IOCHRDY <= ~wait_now;
         O_IOCHRDY_OE <= wait_now;
         O_SYS_CLR <= sys_clr;
      end
   end

   // Checks
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_B);

   full_dec_a: assert property (!man_mode && I_CFG_DONE && !aen_lvl && addr_lvl[15:3] == I_BASE_A[15:3]
      |-> hit_a) else $error("auto decode missed channel A");
   man_dec_a: assert property (man_mode && !aen_lvl && addr_lvl[10:3] == I_BASE_B[10:3] && !dec_a
      |-> hit_b) else $error("manual decode missed channel B");
   reg_addr_a: assert property (O_RD_STB && O_SEL_A |-> O_REG_ADDR == $past(addr_lvl[2:0]))
      else $error("wrong register address");
   pp_addr_a: assert property (O_WR_STB && O_SEL_P |-> O_REG_ADDR[2] == 1'b0)
      else $error("printer address uses bit 2");
   aen_block_a: assert property (aen_lvl && !dack_sel |-> !hit) else $error("I/O decoded under AEN");
   rd_seq_a: assert property (ior_fall && hit && !sys_clr && !$past(sys_clr) |=> O_RD_STB ##1 rd_oe_pend)
      else $error("read strobe sequence broken");
   rd_data_a: assert property (rd_oe_pend && !ior_rise && !sys_clr |=> O_DATA == $past(rd_mux) && O_DATA_OE)
      else $error("read data not captured");
   wr_data_a: assert property (iow_rise && hit && !sys_clr |=> O_WR_STB && O_WR_DATA == $past(data_lvl))
      else $error("write data not latched");
   bus_float_a: assert property (O_DATA_OE |-> $past(!ior_lvl) && $past(rd_act))
      else $error("data driven outside a read");
   irq_route_a: assert property (I_INT_A && I_IRQ_SEL_A < 4'ha && !sys_clr
      |=> O_IRQ[$past(I_IRQ_SEL_A)] && O_IRQ_OE[$past(I_IRQ_SEL_A)]) else $error("interrupt not routed");
   irq_float_a: assert property (I_IRQ_SEL_A == IRQ_NONE && I_IRQ_SEL_B == IRQ_NONE && I_IRQ_SEL_P == IRQ_NONE
      |=> O_IRQ_OE == '0) else $error("unrouted interrupt line driven");
   dreq_mode_a: assert property (!I_DMA_EN |=> O_DREQ == '0 && O_DREQ_OE == '0)
      else $error("DMA request outside ECP/FIFO mode");
   ready_a: assert property (O_IOCHRDY_OE |-> !O_IOCHRDY && $past(I_PP_WAIT))
      else $error("channel ready misdriven");
   tc_a: assert property (O_TC_DONE |-> $past(dack_sel) && $past(tc_rise)) else $error("stray TC done");
   sys_rst_a: assert property (rst_lvl [*3] |=> sys_clr ##1 !O_DATA_OE && O_DREQ_OE == '0 && O_IRQ_OE == '0)
      else $error("system reset did not clear");

   rd_c: cover property (O_RD_STB ##[1:4] O_DATA_OE);
   wr_c: cover property (O_WR_STB && O_SEL_B);
   tc_c: cover property (O_DMA_ACK ##[1:20] O_TC_DONE);
   wait_c: cover property (O_IOCHRDY_OE && O_SEL_P);
endmodule
`default_nettype wire

// >>> hba_host_model.sv
// Behavioural ISA host: CPU read and write cycles, DMA acknowledge, TC and reset.
// Assumes the caller steps it from the falling edge of the core clock.
`timescale 1ns/1ps
`default_nettype none
module hba_host_model (
   input wire logic i_clk,
   input wire logic [7:0] i_dev_data,
   input wire logic i_dev_oe,
   output logic [15:0] o_addr,
   output logic o_aen,
   output logic o_ior_b,
   output logic o_iow_b,
   output logic [7:0] o_bus,
   output logic [3:0] o_dack_b,
   output logic o_tc,
   output logic o_reset
);
   logic [7:0] drv_d = 8'h00; // Host write data
   logic drv_on = 1'b0; // Host owns the data bus
   logic [7:0] last_d = 8'h00; // Last level seen on the bus
   // Released bus toggles every cycle so a stale byte never looks valid
   assign o_bus = i_dev_oe ? i_dev_data : (drv_on ? drv_d : ~last_d);
   always @(posedge i_clk)
      last_d <= o_bus;
   // Idle bus: strobes and acknowledges high, AEN low
   initial begin
      o_addr = 16'h0000;
      o_ior_b = 1'b1;
      o_iow_b = 1'b1;
      pins(1'b0, 4'hf, 1'b0, 1'b0);
   end
   // Sideband pins; AEN low when unused, TC only while an acknowledge is low
   task automatic pins(input logic aen, input logic [3:0] dack_b, input logic tc, input logic rst);
      o_aen = aen;
      o_dack_b = dack_b;
      o_tc = tc;
      o_reset = rst;
      @(negedge i_clk);
   endtask
   // One I/O cycle; address and data outlive the strobe since the pins are filtered
   task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d, input int hold,
                     output logic [7:0] q);
      @(negedge i_clk);
      o_addr = a;
      drv_d = d;
      drv_on = wr;
      repeat (2) @(negedge i_clk);
      o_iow_b = ~wr;
      o_ior_b = wr;
      repeat (hold) @(negedge i_clk);
      q = o_bus;
      o_iow_b = 1'b1;
      o_ior_b = 1'b1;
      repeat (5) @(negedge i_clk);
      drv_on = 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> hba_port_tb.sv
// Self-checking bench for the ISA host port: decode, strobes, IRQ, DMA, wait states, reset.
// Assumes the host model drives the ISA pins; targets behind the port are plain values.
`timescale 1ns/1ps
`default_nettype none
module hba_port_tb
   import hba_pkg::*;
;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic man_b = 1'b1;
   logic [15:0] base_a, base_b, base_p;
   logic [7:0] rd_a = 8'h00, rd_b = 8'h00, rd_p = 8'h00;
   logic int_a = 1'b0, int_b = 1'b0, int_p = 1'b0;
   logic [3:0] irq_a = IRQ_NONE, irq_b = IRQ_NONE, irq_p = IRQ_NONE;
   logic dma_en = 1'b0, pp_dreq = 1'b0, pp_wait = 1'b0;
   logic cfg_done = 1'b1;
   logic [1:0] dma_sel = 2'h0;
   wire [15:0] addr;
   wire aen, ior_b, iow_b, tc, sys_rst, tgt_a, tgt_b, tgt_p, rd_stb, wr_stb, oe;
   wire dma_ack, tc_done, rdy, rdy_oe, sys_clr, dma_cyc_o;
   wire [7:0] bus, o_data, wr_data;
   wire [3:0] dack_b, dreq, dreq_oe;
   wire [2:0] reg_addr;
   wire [9:0] irq, irq_oe;
   int bad_count = 0, n_checks = 0, wr_cnt = 0, rd_cnt = 0, tc_cnt = 0;

   hba_host_model host (.i_clk(mclk), .i_dev_data(o_data), .i_dev_oe(oe), .o_addr(addr),
      .o_aen(aen), .o_ior_b(ior_b), .o_iow_b(iow_b), .o_bus(bus), .o_dack_b(dack_b),
      .o_tc(tc), .o_reset(sys_rst));
   hba_port dut (.I_MCLK(mclk), .I_RST_B(rst_b), .I_RESET(sys_rst), .I_MAN_B(man_b),
      .I_ADDR(addr), .I_AEN(aen), .I_IOR_B(ior_b), .I_IOW_B(iow_b), .I_DATA(bus),
      .O_DATA(o_data), .O_DATA_OE(oe), .I_CFG_DONE(cfg_done), .I_BASE_A(base_a),
      .I_BASE_B(base_b), .I_BASE_P(base_p), .O_SEL_A(tgt_a), .O_SEL_B(tgt_b), .O_SEL_P(tgt_p),
      .O_DMA_CYC(dma_cyc_o), .O_REG_ADDR(reg_addr), .O_RD_STB(rd_stb), .O_WR_STB(wr_stb),
      .O_WR_DATA(wr_data), .I_RD_DATA_A(rd_a), .I_RD_DATA_B(rd_b), .I_RD_DATA_P(rd_p),
      .I_INT_A(int_a), .I_INT_B(int_b), .I_INT_P(int_p), .I_IRQ_SEL_A(irq_a),
      .I_IRQ_SEL_B(irq_b), .I_IRQ_SEL_P(irq_p), .O_IRQ(irq), .O_IRQ_OE(irq_oe),
      .I_DMA_EN(dma_en), .I_DMA_SEL(dma_sel), .I_PP_DREQ(pp_dreq), .O_DREQ(dreq),
      .O_DREQ_OE(dreq_oe), .I_DACK_B(dack_b), .I_TC(tc), .O_DMA_ACK(dma_ack),
      .O_TC_DONE(tc_done), .I_PP_WAIT(pp_wait), .O_IOCHRDY(rdy), .O_IOCHRDY_OE(rdy_oe),
      .O_SYS_CLR(sys_clr));

   // Core clock, 25 ns period
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   // Count one-cycle pulses mid-cycle, where registered outputs have settled
   always @(negedge mclk) begin
      wr_cnt += int'(wr_stb);
      rd_cnt += int'(rd_stb);
      tc_cnt += int'(tc_done);
   end
   // Values of any width are widened to 16 bits before comparing
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Expected target, one-hot {printer, B, A}; A wins over B over printer
   function automatic logic [2:0] exp_sel(input logic [15:0] a, input logic man);
      logic [15:0] m;
      m = man ? MAN_MASK : AUTO_MASK;
      return (((a ^ base_a) & m & UART_SPAN_MASK) == 16'h0) ? 3'h1 :
         (((a ^ base_b) & m & UART_SPAN_MASK) == 16'h0) ? 3'h2 :
         (((a ^ base_p) & m & PP_SPAN_MASK) == 16'h0) ? 3'h4 : 3'h0;
   endfunction
   // One host access with random strobe length, then every visible effect compared
   task automatic access(input logic wr, input logic [15:0] a, input logic aen);
      logic [2:0] hit;
      logic [7:0] d, q, want;
      int w0, r0;
      // AEN without acknowledge, or auto mode before configuration, is refused
      hit = (aen || (man_b && !cfg_done)) ? 3'h0 : exp_sel(a, ~man_b);
      d = 8'($urandom);
      want = hit[0] ? rd_a : (hit[1] ? rd_b : rd_p);
      w0 = wr_cnt;
      r0 = rd_cnt;
      host.pins(aen, 4'hf, 1'b0, 1'b0);
      host.io(wr, a, d, wr ? 3 + $urandom % 4 : 10 + $urandom % 3, q);
      host.pins(1'b0, 4'hf, 1'b0, 1'b0);
      repeat (2) @(negedge mclk);
      chk_val(16'(wr_cnt - w0 + rd_cnt - r0), {15'h0, hit != 3'h0});
      if (hit != 3'h0) begin
         chk_val({12'h0, dma_cyc_o, tgt_p, tgt_b, tgt_a}, {13'h0, hit});
         chk_val({13'h0, reg_addr}, {13'h0, hit[2] ? {1'b0, a[1:0]} : a[2:0]});
         chk_val({8'h0, wr ? wr_data : q}, {8'h0, wr ? d : want});
      end
      // Bus and channel ready are released once the strobe is back high
      chk_val({14'h0, oe, rdy_oe}, 16'h0);
   endtask
   // Verdict and end of run
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Watchdog, far beyond the fewer than a thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      logic [15:0] a;
      logic [7:0] q;
      int w;
      void'($urandom(32'hc88a));
      base_a = {5'($urandom), 11'h3f8};
      base_b = {5'($urandom), 11'h2f8};
      base_p = {5'($urandom), 11'h378};
      repeat (10) @(negedge mclk);
      rst_b = 1'b1;
      repeat (2) @(negedge mclk);
      // Both modes, all targets, aliases above the low eleven lines, AEN refusals
      for (int i = 0; i < 24; i++) begin
         man_b = i[3];
         // One auto mode pass before configuration has finished
         cfg_done = (i != 10);
         rd_a = 8'($urandom);
         rd_b = 8'($urandom);
         rd_p = 8'($urandom);
         w = $urandom % 3;
         a = w == 0 ? base_a + 16'($urandom % 8) : (w == 1 ? base_b + 16'($urandom % 8)
            : base_p + 16'($urandom % 4));
         if (i % 4 == 3)
            a = a ^ 16'h8000;
         access(i[0], a, i % 8 == 5);
      end
      cfg_done = 1'b1;
      // Every interrupt slot, with a second routed but quiet source sharing the enables
      int_b = 1'b1;
      for (int s = 0; s < 10; s++) begin
         irq_a = 4'(s);
         irq_p = 4'((s + 1) % 10);
         int_a = 1'b1;
         repeat (3) @(negedge mclk);
         chk_val({6'h0, irq}, 16'(1 << s));
         chk_val({6'h0, irq_oe}, 16'((1 << s) | (1 << ((s + 1) % 10))));
         int_a = 1'b0;
         repeat (3) @(negedge mclk);
         chk_val({6'h0, irq}, 16'h0);
      end
      // Each DMA slot: request, acknowledge, terminal count
      dma_en = 1'b1;
      for (int c = 0; c < 4; c++) begin
         dma_sel = 2'(c);
         pp_dreq = 1'($urandom);
         repeat (3) @(negedge mclk);
         chk_val({12'h0, dreq}, 16'(pp_dreq) << c);
         chk_val({12'h0, dreq_oe}, 16'h1 << c);
         w = tc_cnt;
         host.pins(1'b1, ~(4'h1 << c), 1'b0, 1'b0);
         repeat (5) @(negedge mclk);
         chk_val({15'h0, dma_ack}, 16'h1);
         // A DMA write reaches the printer data register whatever the address
         a = 16'($urandom);
         host.io(1'b1, a, a[7:0], 4, q);
         chk_val({9'h0, dma_cyc_o, tgt_p, tgt_b, tgt_a, reg_addr}, 16'h60);
         chk_val({8'h0, wr_data}, {8'h0, a[7:0]});
         host.pins(1'b1, ~(4'h1 << c), 1'b1, 1'b0);
         repeat (5) @(negedge mclk);
         host.pins(1'b0, 4'hf, 1'b0, 1'b0);
         repeat (5) @(negedge mclk);
         chk_val(16'(tc_cnt - w), 16'h1);
         chk_val({15'h0, dma_ack}, 16'h0);
      end
      dma_en = 1'b0;
      repeat (3) @(negedge mclk);
      chk_val({12'h0, dreq_oe}, 16'h0);
      // Printer read while the port asks for wait states
      pp_wait = 1'b1;
      fork
         access(1'b0, base_p + 16'h1, 1'b0);
         begin
            repeat (12) @(negedge mclk);
            chk_val({14'h0, rdy_oe, rdy}, 16'h2);
         end
      join
      pp_wait = 1'b0;
      // System reset pulse clears selects and interrupt enables
      host.pins(1'b0, 4'hf, 1'b0, 1'b1);
      repeat (8) @(negedge mclk);
      chk_val({11'h0, sys_clr, tgt_p, tgt_b, tgt_a, |irq_oe}, 16'h10);
      host.pins(1'b0, 4'hf, 1'b0, 1'b0);
      repeat (6) @(negedge mclk);
      chk_val({15'h0, sys_clr}, 16'h0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
